// ### src/decoder_pkg.sv
// Constants and types shared by the opcode and operand decoder.
package decoder_pkg;

  localparam logic [7:0] OP_NEAR_CALL = 8'hE8;
  localparam logic [7:0] OP_NEAR_JUMP = 8'hE9;
  localparam logic [7:0] OP_SHORT_JUMP = 8'hEB;
  localparam logic [7:0] OP_FAR_CALL = 8'h9A;
  localparam logic [7:0] OP_FAR_JUMP = 8'hEA;
  localparam logic [7:0] OP_NEAR_RETURN = 8'hC3;
  localparam logic [7:0] OP_NEAR_RETURN_IMM = 8'hC2;
  localparam logic [7:0] OP_FAR_RETURN = 8'hCB;
  localparam logic [7:0] OP_FAR_RETURN_IMM = 8'hCA;
  localparam logic [7:0] OP_GROUP_FF = 8'hFF;
  localparam logic [7:0] OP_LOCK = 8'hF0;
  localparam logic [7:0] OP_REP_NZ = 8'hF2;
  localparam logic [7:0] OP_REP_Z = 8'hF3;
  localparam logic [7:0] OP_CARRY_INVERT = 8'hF5;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hF8;
  localparam logic [7:0] OP_CARRY_SET = 8'hF9;
  localparam logic [7:0] OP_INT_DISABLE = 8'hFA;
  localparam logic [7:0] OP_INT_ENABLE = 8'hFB;
  localparam logic [7:0] OP_DIR_CLEAR = 8'hFC;
  localparam logic [7:0] OP_DIR_SET = 8'hFD;

  localparam logic [7:0] SEG_PREFIX_MASK = 8'hE7;
  localparam logic [7:0] SEG_PREFIX_VAL = 8'h26;
  localparam logic [7:0] COPROC_MASK = 8'hF8;
  localparam logic [7:0] COPROC_VAL = 8'hD8;
  localparam logic [7:0] ALU_IMM_MASK = 8'hFC;
  localparam logic [7:0] ALU_IMM_VAL = 8'h80;
  localparam logic [7:0] SHIFT_MASK = 8'hFC;
  localparam logic [7:0] SHIFT_VAL = 8'hD0;
  localparam logic [7:0] ALU_REGMEM_MASK = 8'hC4;
  localparam logic [7:0] ALU_REGMEM_VAL = 8'h00;
  localparam logic [7:0] STR_CMP_MASK = 8'hF6;
  localparam logic [7:0] STR_CMP_VAL = 8'hA6;

  localparam int BIT_WIDTH = 0;
  localparam int BIT_DIR = 1;
  localparam int BIT_SIGN = 1;
  localparam int BIT_COUNT_SRC = 1;
  localparam int BIT_REP_Z = 0;
  localparam int FLD_MOD_LSB = 6;
  localparam int FLD_REG_LSB = 3;
  localparam int FLD_RM_LSB = 0;
  localparam int FLD_SEG_LSB = 3;

  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SW_FULL_WORD = 2'h1;
  localparam logic [1:0] SW_SEXT_BYTE = 2'h3;

  localparam logic [2:0] EXT_IND_NEAR_CALL = 3'h2;
  localparam logic [2:0] EXT_IND_FAR_CALL = 3'h3;
  localparam logic [2:0] EXT_IND_NEAR_JUMP = 3'h4;
  localparam logic [2:0] EXT_IND_FAR_JUMP = 3'h5;

  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_COUNT = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_BASE = 3'h3;
  localparam logic [2:0] REG_STACK_PTR = 3'h4;
  localparam logic [2:0] REG_BASE_PTR = 3'h5;
  localparam logic [2:0] REG_SRC_INDEX = 3'h6;
  localparam logic [2:0] REG_DEST_INDEX = 3'h7;

  localparam int SW_OVERFLOW = 11;
  localparam int SW_DIRECTION = 10;
  localparam int SW_INT = 9;
  localparam int SW_INT_DUP = 8;
  localparam int SW_SIGN = 7;
  localparam int SW_ZERO = 6;
  localparam int SW_AUX = 4;
  localparam int SW_PARITY = 2;
  localparam int SW_CARRY = 0;

  localparam logic FLAG_RESET = 1'h0;
  localparam logic [7:0] SHIFT_ONE = 8'h01;

  typedef enum logic [4:0] {
    IC_OTHER, IC_NEAR_CALL, IC_NEAR_JUMP, IC_SHORT_JUMP, IC_FAR_CALL, IC_FAR_JUMP,
    IC_NEAR_RETURN, IC_NEAR_RETURN_IMM, IC_FAR_RETURN, IC_FAR_RETURN_IMM,
    IC_GROUP_FF, IC_IND_NEAR_CALL, IC_IND_FAR_CALL, IC_IND_NEAR_JUMP, IC_IND_FAR_JUMP,
    IC_ALU_REGMEM, IC_ALU_IMM, IC_SHIFT_ROT, IC_FLAG_CTRL, IC_COPROC, IC_STRING_CMP
  } insn_class_t;

endpackage

// ### src/ea_calc.sv
// Effective address adder for the memory operand forms.
`timescale 1ns/1ps
`default_nettype none

module ea_calc
  import decoder_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input wire logic [1:0] mode_in,
  input wire logic [2:0] selector_in,
  input wire logic [WORD_W-1:0] disp_in,
  input wire logic [WORD_W-1:0] base_reg_in,
  input wire logic [WORD_W-1:0] base_pointer_in,
  input wire logic [WORD_W-1:0] src_index_in,
  input wire logic [WORD_W-1:0] dest_index_in,
  output logic [WORD_W-1:0] effective_address_out
);

  logic [WORD_W-1:0] base_sum;

  always_comb begin
    case (selector_in)
      3'h0: base_sum = base_reg_in + src_index_in;
      3'h1: base_sum = base_reg_in + dest_index_in;
      3'h2: base_sum = base_pointer_in + src_index_in;
      3'h3: base_sum = base_pointer_in + dest_index_in;
      3'h4: base_sum = src_index_in;
      3'h5: base_sum = dest_index_in;
      3'h6: base_sum = (mode_in == MOD_NODISP) ? '0 : base_pointer_in;
      default: base_sum = base_reg_in;
    endcase
  end

  assign effective_address_out = base_sum + disp_in;

endmodule

`default_nettype wire

// ### src/opcode_operand_decoder.sv
// Instruction byte decoder for control transfer, operand and prefix fields.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - E8 is near call, two displacement bytes.
// - E9 near jump word, EB short byte.
// - 9A far call with offset and segment.
// - C3 near return, C2 adds immediate.
// - CB far return, CA adds immediate.
// - Direction bit set means register is destination.
// - Width bit selects word or byte.
// - Mode 11 makes selector a register.
// - Mode 00 no displacement, except direct address.
// - Mode 01 byte sign-extended, 10 full word.
// - Selector picks base and index sum.
// - Displacement precedes immediate data bytes.
// - Sign-width 01 word, 11 extended byte.
// - Count bit selects one or count low.
// - Compare-sense bit versus zero flag decides repeat.
// - Segment prefix overrides next access segment.
// - Status word packs flags at fixed bits.
// - Carry invert and carry set exist.
// - Direction clear and set exist.
// - Interrupt disable and enable exist.
// - Coprocessor handoff carries extension and address.
// - Lock prefix holds bus lock through next.
module opcode_operand_decoder
  import decoder_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] byte_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  input wire logic [WORD_W-1:0] base_reg_in,
  input wire logic [WORD_W-1:0] base_pointer_in,
  input wire logic [WORD_W-1:0] src_index_in,
  input wire logic [WORD_W-1:0] dest_index_in,
  input wire logic [WORD_W-1:0] count_reg_in,
  input wire logic overflow_flag_in,
  input wire logic sign_flag_in,
  input wire logic zero_flag_in,
  input wire logic aux_carry_flag_in,
  input wire logic parity_flag_in,
  output logic insn_done_out,
  output insn_class_t insn_class_out,
  output logic [7:0] opcode_out,
  output logic word_op_out,
  output logic reg_is_dest_out,
  output logic [2:0] dest_sel_out,
  output logic [2:0] src_sel_out,
  output logic rm_is_reg_out,
  output logic [WORD_W-1:0] effective_address_out,
  output logic [WORD_W-1:0] disp_out,
  output logic [WORD_W-1:0] operand_out,
  output logic [WORD_W-1:0] segment_out,
  output logic [7:0] shift_count_out,
  output logic [2:0] coproc_ext_out,
  output logic seg_override_valid_out,
  output logic [1:0] seg_override_out,
  output logic repeat_active_out,
  output logic repeat_continue_out,
  output logic bus_lock_out,
  output logic [15:0] status_word_out
);

  typedef enum logic [2:0] {S_OPCODE, S_MODRM, S_DISP, S_IMM, S_DONE} state_t;

  function automatic logic [WORD_W-1:0] sext8(input logic [7:0] b);
    sext8 = {{(WORD_W-8){b[7]}}, b};
  endfunction

  state_t state_q;
  insn_class_t class_q;
  insn_class_t dec_class;
  logic [7:0] opcode_q;
  logic [7:0] modrm_q;
  logic [7:0] disp_b [2];
  logic [7:0] opnd_b [4];
  logic [2:0] imm_need_q;
  logic [1:0] disp_need_q;
  logic [2:0] idx_q;
  logic dec_modrm;
  logic [2:0] dec_imm;
  logic [1:0] mod_disp;
  logic take;
  logic is_seg_prefix;
  logic is_prefix;
  logic seg_valid_q;
  logic [1:0] seg_q;
  logic rep_active_q;
  logic rep_z_q;
  logic lock_q;
  logic carry_flag_q;
  logic direction_flag_q;
  logic interrupt_flag_q;
  logic [WORD_W-1:0] disp_val;
  logic [WORD_W-1:0] ea_val;
  logic [1:0] mod_f;
  logic [2:0] reg_f;
  logic [2:0] rm_f;

  assign byte_ready_out = (state_q != S_DONE);
  assign take = byte_valid_in && byte_ready_out;
  assign is_seg_prefix = (byte_in & SEG_PREFIX_MASK) == SEG_PREFIX_VAL;
  assign is_prefix = is_seg_prefix || byte_in == OP_LOCK || byte_in == OP_REP_NZ
                     || byte_in == OP_REP_Z;
  assign mod_f = modrm_q[FLD_MOD_LSB +: 2];
  assign reg_f = modrm_q[FLD_REG_LSB +: 3];
  assign rm_f = modrm_q[FLD_RM_LSB +: 3];

  // Opcode byte classification and the count of trailing bytes it implies.
  always_comb begin
    dec_class = IC_OTHER;
    dec_modrm = 1'h0;
    dec_imm = 3'h0;
    case (byte_in)
      OP_NEAR_CALL: begin
        dec_class = IC_NEAR_CALL;
        dec_imm = 3'h2;
      end
      OP_NEAR_JUMP: begin
        dec_class = IC_NEAR_JUMP;
        dec_imm = 3'h2;
      end
      OP_SHORT_JUMP: begin
        dec_class = IC_SHORT_JUMP;
        dec_imm = 3'h1;
      end
      OP_FAR_CALL: begin
        dec_class = IC_FAR_CALL;
        dec_imm = 3'h4;
      end
      OP_FAR_JUMP: begin
        dec_class = IC_FAR_JUMP;
        dec_imm = 3'h4;
      end
      OP_NEAR_RETURN: dec_class = IC_NEAR_RETURN;
      OP_NEAR_RETURN_IMM: begin
        dec_class = IC_NEAR_RETURN_IMM;
        dec_imm = 3'h2;
      end
      OP_FAR_RETURN: dec_class = IC_FAR_RETURN;
      OP_FAR_RETURN_IMM: begin
        dec_class = IC_FAR_RETURN_IMM;
        dec_imm = 3'h2;
      end
      OP_GROUP_FF: begin
        dec_class = IC_GROUP_FF;
        dec_modrm = 1'h1;
      end
      OP_CARRY_INVERT, OP_CARRY_CLEAR, OP_CARRY_SET, OP_INT_DISABLE, OP_INT_ENABLE,
      OP_DIR_CLEAR, OP_DIR_SET: dec_class = IC_FLAG_CTRL;
      default: begin
        if ((byte_in & ALU_REGMEM_MASK) == ALU_REGMEM_VAL) begin
          dec_class = IC_ALU_REGMEM;
          dec_modrm = 1'h1;
        end else if ((byte_in & ALU_IMM_MASK) == ALU_IMM_VAL) begin
          dec_class = IC_ALU_IMM;
          dec_modrm = 1'h1;
          dec_imm = (byte_in[1:0] == SW_FULL_WORD) ? 3'h2 : 3'h1;
        end else if ((byte_in & SHIFT_MASK) == SHIFT_VAL) begin
          dec_class = IC_SHIFT_ROT;
          dec_modrm = 1'h1;
        end else if ((byte_in & COPROC_MASK) == COPROC_VAL) begin
          dec_class = IC_COPROC;
          dec_modrm = 1'h1;
        end else if ((byte_in & STR_CMP_MASK) == STR_CMP_VAL) begin
          dec_class = IC_STRING_CMP;
        end
      end
    endcase
  end

  // Displacement bytes implied by the addressing form.
  always_comb begin
    case (byte_in[FLD_MOD_LSB +: 2])
      MOD_DISP8: mod_disp = 2'h1;
      MOD_DISP16: mod_disp = 2'h2;
      MOD_NODISP: mod_disp = (byte_in[FLD_RM_LSB +: 3] == RM_DIRECT) ? 2'h2 : 2'h0;
      default: mod_disp = 2'h0;
    endcase
  end

  // Byte sequencing: opcode, operand selector, displacement, then immediate.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_OPCODE;
      idx_q <= 3'h0;
      imm_need_q <= 3'h0;
      disp_need_q <= 2'h0;
    end else begin
      case (state_q)
        S_OPCODE: begin
          if (take && !is_prefix) begin
            imm_need_q <= dec_imm;
            disp_need_q <= 2'h0;
            idx_q <= 3'h0;
            if (dec_modrm) begin
              state_q <= S_MODRM;
            end else if (dec_imm != 3'h0) begin
              state_q <= S_IMM;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_MODRM: begin
          if (take) begin
            disp_need_q <= mod_disp;
            if (mod_disp != 2'h0) begin
              state_q <= S_DISP;
            end else if (imm_need_q != 3'h0) begin
              state_q <= S_IMM;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_DISP: begin
          if (take) begin
            if (idx_q + 3'h1 == {1'h0, disp_need_q}) begin
              idx_q <= 3'h0;
              state_q <= (imm_need_q != 3'h0) ? S_IMM : S_DONE;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
        end
        S_IMM: begin
          if (take) begin
            if (idx_q + 3'h1 == imm_need_q) begin
              state_q <= S_DONE;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
        end
        default: state_q <= S_OPCODE;
      endcase
    end
  end

  // Instruction bytes are captured into indexed storage.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      opcode_q <= 8'h00;
      modrm_q <= 8'h00;
      class_q <= IC_OTHER;
      disp_b <= '{default: 8'h00};
      opnd_b <= '{default: 8'h00};
    end else if (take) begin
      if (state_q == S_OPCODE && !is_prefix) begin
        opcode_q <= byte_in;
        class_q <= dec_class;
        modrm_q <= 8'h00;
        disp_b <= '{default: 8'h00};
        opnd_b <= '{default: 8'h00};
      end
      if (state_q == S_MODRM) begin
        modrm_q <= byte_in;
      end
      if (state_q == S_DISP) begin
        disp_b[idx_q[0]] <= byte_in;
      end
      if (state_q == S_IMM) begin
        opnd_b[idx_q[1:0]] <= byte_in;
      end
    end
  end

  // Prefix state applies to the next instruction and ends with it.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      seg_valid_q <= 1'h0;
      seg_q <= SEG_EXTRA;
      rep_active_q <= 1'h0;
      rep_z_q <= 1'h0;
      lock_q <= 1'h0;
    end else if (state_q == S_DONE) begin
      seg_valid_q <= 1'h0;
      rep_active_q <= 1'h0;
      lock_q <= 1'h0;
    end else if (take && state_q == S_OPCODE) begin
      if (is_seg_prefix) begin
        seg_valid_q <= 1'h1;
        seg_q <= byte_in[FLD_SEG_LSB +: 2];
      end
      if (byte_in == OP_REP_NZ || byte_in == OP_REP_Z) begin
        rep_active_q <= 1'h1;
        rep_z_q <= byte_in[BIT_REP_Z];
      end
      if (byte_in == OP_LOCK) begin
        lock_q <= 1'h1;
      end
    end
  end

  // Processor-control flag changes.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      carry_flag_q <= FLAG_RESET;
      direction_flag_q <= FLAG_RESET;
      interrupt_flag_q <= FLAG_RESET;
    end else if (take && state_q == S_OPCODE) begin
      case (byte_in)
        OP_CARRY_INVERT: carry_flag_q <= !carry_flag_q;
        OP_CARRY_SET: carry_flag_q <= 1'h1;
        OP_CARRY_CLEAR: carry_flag_q <= 1'h0;
        OP_DIR_CLEAR: direction_flag_q <= 1'h0;
        OP_DIR_SET: direction_flag_q <= 1'h1;
        OP_INT_DISABLE: interrupt_flag_q <= 1'h0;
        OP_INT_ENABLE: interrupt_flag_q <= 1'h1;
        default: carry_flag_q <= carry_flag_q;
      endcase
    end
  end

  always_comb begin
    case (mod_f)
      MOD_DISP8: disp_val = sext8(disp_b[0]);
      MOD_DISP16: disp_val = {disp_b[1], disp_b[0]};
      MOD_NODISP: disp_val = (rm_f == RM_DIRECT) ? {disp_b[1], disp_b[0]} : '0;
      default: disp_val = '0;
    endcase
  end

  ea_calc #(
    .WORD_W(WORD_W)
  ) u_ea_calc (
    .mode_in(mod_f),
    .selector_in(rm_f),
    .disp_in(disp_val),
    .base_reg_in(base_reg_in),
    .base_pointer_in(base_pointer_in),
    .src_index_in(src_index_in),
    .dest_index_in(dest_index_in),
    .effective_address_out(ea_val)
  );

  // Decoded results are registered when the last byte has been taken.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      insn_done_out <= 1'h0;
      insn_class_out <= IC_OTHER;
      opcode_out <= 8'h00;
      word_op_out <= 1'h0;
      reg_is_dest_out <= 1'h0;
      dest_sel_out <= REG_ACC;
      src_sel_out <= REG_ACC;
      rm_is_reg_out <= 1'h0;
      effective_address_out <= '0;
      disp_out <= '0;
      operand_out <= '0;
      segment_out <= '0;
      shift_count_out <= 8'h00;
      coproc_ext_out <= 3'h0;
      repeat_continue_out <= 1'h0;
    end else begin
      insn_done_out <= (state_q == S_DONE);
      if (state_q == S_DONE) begin
        opcode_out <= opcode_q;
        word_op_out <= opcode_q[BIT_WIDTH];
        reg_is_dest_out <= opcode_q[BIT_DIR];
        dest_sel_out <= opcode_q[BIT_DIR] ? reg_f : rm_f;
        src_sel_out <= opcode_q[BIT_DIR] ? rm_f : reg_f;
        rm_is_reg_out <= (mod_f == MOD_REG);
        effective_address_out <= (mod_f == MOD_REG) ? '0 : ea_val;
        disp_out <= disp_val;
        segment_out <= {opnd_b[3], opnd_b[2]};
        coproc_ext_out <= reg_f;
        shift_count_out <= opcode_q[BIT_COUNT_SRC] ? count_reg_in[7:0] : SHIFT_ONE;
        repeat_continue_out <= rep_active_q && (zero_flag_in == rep_z_q);
        if (class_q == IC_SHORT_JUMP ||
            (class_q == IC_ALU_IMM && opcode_q[1:0] == SW_SEXT_BYTE)) begin
          operand_out <= sext8(opnd_b[0]);
        end else if (class_q == IC_ALU_IMM && !opcode_q[BIT_SIGN] && !opcode_q[BIT_WIDTH]) begin
          operand_out <= {8'h00, opnd_b[0]};
        end else begin
          operand_out <= {opnd_b[1], opnd_b[0]};
        end
        if (class_q == IC_GROUP_FF) begin
          case (reg_f)
            EXT_IND_NEAR_CALL: insn_class_out <= IC_IND_NEAR_CALL;
            EXT_IND_FAR_CALL: insn_class_out <= IC_IND_FAR_CALL;
            EXT_IND_NEAR_JUMP: insn_class_out <= IC_IND_NEAR_JUMP;
            EXT_IND_FAR_JUMP: insn_class_out <= IC_IND_FAR_JUMP;
            default: insn_class_out <= IC_OTHER;
          endcase
        end else begin
          insn_class_out <= class_q;
        end
      end
    end
  end

  // Status word packing, registered every cycle.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status_word_out <= 16'h0000;
    end else begin
      status_word_out <= 16'h0000;
      status_word_out[SW_OVERFLOW] <= overflow_flag_in;
      status_word_out[SW_DIRECTION] <= direction_flag_q;
      status_word_out[SW_INT] <= interrupt_flag_q;
      status_word_out[SW_INT_DUP] <= interrupt_flag_q;
      status_word_out[SW_SIGN] <= sign_flag_in;
      status_word_out[SW_ZERO] <= zero_flag_in;
      status_word_out[SW_AUX] <= aux_carry_flag_in;
      status_word_out[SW_PARITY] <= parity_flag_in;
      status_word_out[SW_CARRY] <= carry_flag_q;
    end
  end

  assign seg_override_valid_out = seg_valid_q;
  assign seg_override_out = seg_q;
  assign repeat_active_out = rep_active_q;
  assign bus_lock_out = lock_q;

  property p_near_call_bytes;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_NEAR_CALL)
        |-> ##1 (state_q == S_IMM && imm_need_q == 3'h2);
  endproperty
  a_near_call_bytes: assert property (p_near_call_bytes) else $error("near call bytes");

  property p_short_jump_bytes;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_SHORT_JUMP) |-> ##1 imm_need_q == 3'h1;
  endproperty
  a_short_jump_bytes: assert property (p_short_jump_bytes) else $error("short jump");

  property p_far_call_bytes;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_FAR_CALL) |-> ##1 imm_need_q == 3'h4;
  endproperty
  a_far_call_bytes: assert property (p_far_call_bytes) else $error("far call bytes");

  property p_near_return;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_NEAR_RETURN)
        |-> ##2 (insn_done_out && insn_class_out == IC_NEAR_RETURN);
  endproperty
  a_near_return: assert property (p_near_return) else $error("near return");

  property p_reg_operand;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_MODRM && byte_in[7:6] == MOD_REG) |-> ##1 disp_need_q == 2'h0;
  endproperty
  a_reg_operand: assert property (p_reg_operand) else $error("register form disp");

  property p_shift_one;
    @(posedge mclk_in) disable iff (rst_in)
      (insn_done_out && insn_class_out == IC_SHIFT_ROT && !opcode_out[BIT_COUNT_SRC])
        |-> shift_count_out == SHIFT_ONE;
  endproperty
  a_shift_one: assert property (p_shift_one) else $error("shift count");

  property p_dir_set;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_DIR_SET) |-> ##2 status_word_out[SW_DIRECTION];
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("direction set");

  property p_carry_set;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_CARRY_SET) |-> ##2 status_word_out[SW_CARRY];
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry set");

  property p_lock_held;
    @(posedge mclk_in) disable iff (rst_in)
      (take && state_q == S_OPCODE && byte_in == OP_LOCK) |-> ##1 bus_lock_out;
  endproperty
  a_lock_held: assert property (p_lock_held) else $error("bus lock");

endmodule

`default_nettype wire

// ### verification/byte_feeder.sv
// Program memory model that streams queued instruction bytes.
`timescale 1ns/1ps
`default_nettype none
module byte_feeder (
  input wire logic mclk_in,
  input wire logic ready_in,
  output logic [7:0] byte_out,
  output logic valid_out
);
  logic [7:0] q[$];
  bit took = 0;
  initial begin
    byte_out = 8'h00;
    valid_out = 1'b0;
  end
  task automatic push(input logic [7:0] v);
    q.push_back(v);
  endtask
  always @(posedge mclk_in) begin
    if (valid_out === 1'b1 && ready_in === 1'b1) took = 1;
  end
  // A byte is held until taken; an idle bus shows inverted data, not the old byte.
  always @(negedge mclk_in) begin
    if (took) void'(q.pop_front());
    took = 0;
    valid_out <= (q.size() > 0);
    byte_out <= (q.size() > 0) ? q[0] : ~byte_out;
  end
endmodule
`default_nettype wire

// ### verification/opcode_operand_decoder_tb.sv
// Self-checking bench for the opcode and operand decoder.
`timescale 1ns/1ps
`default_nettype none
module opcode_operand_decoder_tb
  import decoder_pkg::*;
;
  logic clk = 0, rst = 1, vld, rdy, done, wop, rid, rmr, lock, sv, seen_lock;
  logic ovf = 1, sgn = 0, zr = 1, aux = 0, par = 1;
  logic rc;
  logic [7:0] b, sc, opc;
  logic [2:0] ds, ss, ce;
  logic [1:0] so, seen_seg;
  logic [15:0] bx = 16'h1000, bp = 16'h2000, si = 16'h0300, di = 16'h0040, cx = 16'h1205;
  logic [15:0] ea, dp, opd, seg, sw;
  insn_class_t cls;
  int err_count = 0, num_checks = 0;
  byte_feeder byte_feeder_i (.mclk_in(clk), .ready_in(rdy), .byte_out(b), .valid_out(vld));
  opcode_operand_decoder opcode_operand_decoder_i (.mclk_in(clk), .rst_in(rst), .byte_in(b),
    .byte_valid_in(vld), .byte_ready_out(rdy), .base_reg_in(bx), .base_pointer_in(bp),
    .src_index_in(si), .dest_index_in(di), .count_reg_in(cx), .overflow_flag_in(ovf),
    .sign_flag_in(sgn), .zero_flag_in(zr), .aux_carry_flag_in(aux), .parity_flag_in(par),
    .insn_done_out(done), .insn_class_out(cls), .opcode_out(opc), .word_op_out(wop),
    .reg_is_dest_out(rid), .dest_sel_out(ds), .src_sel_out(ss), .rm_is_reg_out(rmr),
    .effective_address_out(ea), .disp_out(dp), .operand_out(opd), .segment_out(seg),
    .shift_count_out(sc), .coproc_ext_out(ce), .seg_override_valid_out(sv),
    .seg_override_out(so), .repeat_active_out(), .repeat_continue_out(rc),
    .bus_lock_out(lock), .status_word_out(sw));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] s[$]);
    foreach (s[k]) byte_feeder_i.push(s[k]);
    seen_lock = 0;
    @(negedge clk);
    for (int n = 0; n < 40 && done !== 1'b1; n++) begin
      @(negedge clk);
      if (lock === 1'b1) seen_lock = 1;
      if (sv === 1'b1) seen_seg = so;
    end
    chk({15'h0, done}, 16'h0001);
  endtask
  task automatic near_call();
    run('{8'hE8, 8'h34, 8'h12});
    chk(16'(cls), 16'(IC_NEAR_CALL));
    chk(opd, 16'h1234);
  endtask
  task automatic far_call();
    run('{8'h9A, 8'h78, 8'h56, 8'h34, 8'h12});
    chk(16'(cls), 16'(IC_FAR_CALL));
    chk(opd, 16'h5678);
    chk(seg, 16'h1234);
  endtask
  task automatic mem_form();
    run('{8'h03, 8'h46, 8'hF0});
    chk(dp, 16'hFFF0);
    chk(ea, 16'h1FF0);
    chk({13'h0, rid, wop, rmr}, 16'h0006);
    chk({10'h0, ds, ss}, 16'h0006);
  endtask
  task automatic shift_reg();
    run('{8'hD3, 8'hC1});
    chk({7'h0, rmr, sc}, 16'h0105);
    chk(ea, 16'h0000);
    run('{8'hD1, 8'hC1});
    chk({8'h0, sc}, 16'h0001);
  endtask
  task automatic prefixed();
    run('{8'hF0, 8'h2E, 8'h01, 8'h06, 8'h34, 8'h12});
    chk({15'h0, seen_lock}, 16'h0001);
    chk({14'h0, seen_seg}, {14'h0, SEG_CODE});
    chk(ea, 16'h1234);
    chk({15'h0, lock}, 16'h0000);
  endtask
  task automatic ctl_xfer();
    run('{8'hEB, 8'h80});
    chk(16'(cls), 16'(IC_SHORT_JUMP));
    chk(opd, 16'hFF80);
    run('{8'hE9, 8'h02, 8'h01});
    chk(16'(cls), 16'(IC_NEAR_JUMP));
    chk(opd, 16'h0102);
    run('{8'hEA, 8'h11, 8'h22, 8'h33, 8'h44});
    chk(16'(cls), 16'(IC_FAR_JUMP));
    chk(opd, 16'h2211);
    chk(seg, 16'h4433);
    run('{8'hC3});
    chk(16'(cls), 16'(IC_NEAR_RETURN));
    run('{8'hC2, 8'h08, 8'h00});
    chk(opd, 16'h0008);
    run('{8'hCB});
    chk(16'(cls), 16'(IC_FAR_RETURN));
    run('{8'hCA, 8'h0A, 8'h00});
    chk(16'(cls), 16'(IC_FAR_RETURN_IMM));
    chk(opd, 16'h000A);
    run('{8'hFF, 8'h1F});
    chk(16'(cls), 16'(IC_IND_FAR_CALL));
    chk(ea, 16'h1000);
    run('{8'hFF, 8'h60, 8'h10});
    chk(16'(cls), 16'(IC_IND_NEAR_JUMP));
    chk(ea, 16'h1310);
  endtask
  task automatic imm_ops();
    run('{8'h83, 8'h80, 8'h04, 8'h00, 8'hFE});
    chk(ea, 16'h1304);
    chk(opd, 16'hFFFE);
    run('{8'h81, 8'hC0, 8'h34, 8'h12});
    chk(opd, 16'h1234);
    run('{8'hF3, 8'hA6});
    chk({15'h0, rc}, 16'h0001);
    run('{8'hDA, 8'h5C, 8'h02});
    chk({13'h0, ce}, 16'h0003);
    chk(ea, 16'h0302);
    chk({8'h0, opc}, 16'h00DA);
  endtask
  task automatic flag_op(input logic [7:0] op, input logic c, input logic d, input logic i);
    run('{op});
    chk(sw, {4'h0, ovf, d, i, i, sgn, zr, 1'b0, aux, 1'b0, par, 1'b0, c});
  endtask
  task automatic summarize();
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    near_call();
    far_call();
    mem_form();
    shift_reg();
    prefixed();
    ctl_xfer();
    imm_ops();
    flag_op(8'hF9, 1, 0, 0);
    flag_op(8'hF5, 0, 0, 0);
    flag_op(8'hFD, 0, 1, 0);
    flag_op(8'hFB, 0, 1, 1);
    flag_op(8'hFC, 0, 0, 1);
    flag_op(8'hFA, 0, 0, 0);
    summarize();
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
